// File: rtl/tsc_pkg.sv
// package: register map, field layout and sizes of the serial port block
// assumes: included ahead of the interface and every design module
package tsc_pkg;
    localparam int WORD_W     = 16;
    localparam int ADDR_W     = 4;
    localparam int DATA_W     = 12;
    localparam int GPIO_W     = 8;
    localparam int PTR_W      = 5;
    localparam int NPIN       = 4;
    localparam int NCHAN      = 4;
    localparam int CNT_W      = 5;
    localparam logic [CNT_W-1:0] FRAME_BITS = 5'h10;

    // write map
    localparam logic [ADDR_W-1:0] WA_DUMMY  = 4'h0;
    localparam logic [ADDR_W-1:0] WA_CTRL1  = 4'h1;
    localparam logic [ADDR_W-1:0] WA_FIRST  = 4'h2;
    localparam logic [ADDR_W-1:0] WA_ALERT  = 4'h3;
    localparam logic [ADDR_W-1:0] WA_LAST   = 4'he;
    localparam logic [ADDR_W-1:0] WA_EXT    = 4'hf;
    // extended map
    localparam logic [ADDR_W-1:0] EA_CFG_A  = 4'h0;
    localparam logic [ADDR_W-1:0] EA_CFG_B  = 4'h1;
    localparam logic [ADDR_W-1:0] EA_DATA   = 4'h2;
    // read map
    localparam logic [PTR_W-1:0]  RA_CFG_A  = 5'h1b;
    localparam logic [PTR_W-1:0]  RA_CFG_B  = 5'h1c;
    localparam logic [PTR_W-1:0]  RA_DATA   = 5'h1d;
    localparam logic [PTR_W-1:0]  RA_MAX    = 5'h1f;

    // read pointer field inside control register 1
    localparam int PTR_LSB = 2;
    // alert register: low status [3:0], high status [7:4], enables [11:8]
    localparam int ST_LO_LSB = 0;
    localparam int ST_HI_LSB = 4;
    localparam int ST_EN_LSB = 8;
    // per-pin nibble in gpio config: en, dir, sense, irq permit
    localparam int F_EN     = 0;
    localparam int F_DIR    = 1;
    localparam int F_SENSE  = 2;
    localparam int F_PERMIT = 3;
    localparam int NIB      = 4;

    localparam logic [DATA_W-1:0] RST12 = 12'h000;
    localparam logic [GPIO_W-1:0] RST8  = 8'h00;
endpackage

// File: rtl/tsc_link_if.sv
// interface: words passing between serial link logic and register core
// assumes: tsc_pkg compiled first
`timescale 1ns/1ps
`default_nettype none
interface tsc_link_if;
    import tsc_pkg::*;
    logic [WORD_W-1:0] rx_word;
    logic              rx_tgl;
    logic [WORD_W-1:0] tx_word;
    modport link (output rx_word, output rx_tgl, input tx_word);
    modport core (input rx_word, input rx_tgl, output tx_word);
endinterface
`default_nettype wire

// File: rtl/tsc_serial_link.sv
// module: shifter on the host's bit clock, one frame per select low
// assumes: bit clock idles low; tx word steady while select is low
`timescale 1ns/1ps
`default_nettype none
module tsc_serial_link
    import tsc_pkg::*;
(
    // link pins
    input  wire logic  sclk,
    input  wire logic  cs_n,
    input  wire logic  ser_in,
    output logic       ser_out,
    output logic       ser_out_oe,
    // system reset
    input  wire logic  resetn,
    // core side
    tsc_link_if.link   lk
);
    logic [CNT_W-1:0]  rx_cnt_r;
    logic [WORD_W-2:0] rx_sh_r;
    logic [CNT_W-1:0]  tx_cnt_r;
    logic              last_bit;

    assign last_bit = (rx_cnt_r == FRAME_BITS - 5'h01);

    // =====================================================
    // receive: select high clears the frame state
    always_ff @(posedge sclk or posedge cs_n)
    begin
        if (cs_n)
        begin
            rx_cnt_r <= '0;
            rx_sh_r  <= '0;
        end
        else if (rx_cnt_r != FRAME_BITS)
        begin
            rx_sh_r  <= {rx_sh_r[WORD_W-3:0], ser_in};
            rx_cnt_r <= rx_cnt_r + 5'h01;
        end
    end

    // word and toggle outlive the frame, so system reset only
    always_ff @(posedge sclk or negedge resetn)
    begin
        if (!resetn)
        begin
            lk.rx_word <= '0;
            lk.rx_tgl  <= 1'b0;
        end
        else if (!cs_n && last_bit)
        begin
            lk.rx_word <= {rx_sh_r, ser_in};
            lk.rx_tgl  <= ~lk.rx_tgl;
        end
    end

    // =====================================================
    // transmit: msb shows as soon as select falls
    always_ff @(negedge sclk or posedge cs_n)
    begin
        if (cs_n)
            tx_cnt_r <= '0;
        else if (rx_cnt_r != '0 && tx_cnt_r != FRAME_BITS)
            tx_cnt_r <= tx_cnt_r + 5'h01;
    end

    always_comb
    begin
        ser_out    = 1'b0;
        ser_out_oe = ~cs_n;
        if (!cs_n && tx_cnt_r != FRAME_BITS)
            ser_out = lk.tx_word[4'(FRAME_BITS - 5'h01 - tx_cnt_r)];
    end
endmodule
`default_nettype wire

// File: rtl/tsc_serial_gpio.sv
// module: register core, gpio pins and alarm output of the serial port
// assumes: limit inputs are one-cycle pulses on CLK from the comparator
`timescale 1ns/1ps
`default_nettype none
module tsc_serial_gpio
    import tsc_pkg::*;
(
    // clock and reset
    input  wire logic               CLK,
    input  wire logic               RESETN,
    // serial link
    input  wire logic               SERIAL_BIT_CLOCK,
    input  wire logic               CS_N,
    input  wire logic               SER_IN,
    output logic                    SER_OUT,
    output logic                    SER_OUT_OE,
    // gpio pins
    input  wire logic [NPIN-1:0]    GPIO_IN,
    output logic      [NPIN-1:0]    GPIO_OUT,
    output logic      [NPIN-1:0]    GPIO_OE,
    output logic      [NPIN-2:0]    AUX_ANALOG,
    // limit comparator
    input  wire logic [NCHAN-1:0]   LIMIT_HI,
    input  wire logic [NCHAN-1:0]   LIMIT_LO,
    // alarm
    output logic                    ALERT_N,
    // register contents for the rest of the device
    output logic      [DATA_W-1:0]  CTRL_WORD,
    output logic                    WR_STROBE,
    output logic      [ADDR_W-1:0]  WR_ADDR,
    output logic      [DATA_W-1:0]  WR_DATA
);
    tsc_link_if lk ();

    // =====================================================
    // link side
    tsc_serial_link u_link (
        .sclk       (SERIAL_BIT_CLOCK),
        .cs_n       (CS_N),
        .ser_in     (SER_IN),
        .ser_out    (SER_OUT),
        .ser_out_oe (SER_OUT_OE),
        .resetn     (RESETN),
        .lk         (lk.link)
    );

    // =====================================================
    // frame event crossing
    logic              tg_s1_r;
    logic              tg_s2_r;
    logic              tg_s3_r;
    logic              frame_ev;
    logic [ADDR_W-1:0] w_addr;
    logic [DATA_W-1:0] w_data;
    logic [ADDR_W-1:0] e_addr;
    logic [GPIO_W-1:0] e_data;

    // word is stable long before the toggle lands, so no word sync
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            tg_s1_r <= 1'b0;
            tg_s2_r <= 1'b0;
            tg_s3_r <= 1'b0;
        end
        else
        begin
            tg_s1_r <= lk.rx_tgl;
            tg_s2_r <= tg_s1_r;
            tg_s3_r <= tg_s2_r;
        end
    end

    assign frame_ev = tg_s2_r ^ tg_s3_r;
    assign w_addr   = lk.rx_word[WORD_W-1 -: ADDR_W];
    assign w_data   = lk.rx_word[DATA_W-1:0];
    assign e_addr   = lk.rx_word[DATA_W-1 -: ADDR_W];
    assign e_data   = lk.rx_word[GPIO_W-1:0];

    function automatic logic ext_hit(input logic [ADDR_W-1:0] a,
                                     input logic [ADDR_W-1:0] wa,
                                     input logic [ADDR_W-1:0] ea);
        ext_hit = (wa == WA_EXT) && (ea == a);
    endfunction

    // =====================================================
    // twelve-bit registers
    logic [DATA_W-1:0] regs_r [WA_CTRL1:WA_LAST];
    logic [PTR_W-1:0]  ptr_r;
    logic              wr_hit;

    assign wr_hit = frame_ev && (w_addr != WA_DUMMY)
                    && (w_addr != WA_EXT);

    genvar gi;
    generate
        for (gi = WA_CTRL1; gi <= WA_LAST; gi++)
        begin : g_reg
            if (gi != WA_ALERT)
            begin : g_plain
                always_ff @(posedge CLK or negedge RESETN)
                begin
                    if (!RESETN)
                        regs_r[gi] <= RST12;
                    else if (wr_hit && w_addr == ADDR_W'(gi))
                        regs_r[gi] <= w_data;
                end
            end
        end
    endgenerate

    assign CTRL_WORD = regs_r[WA_CTRL1];

    // =====================================================
    // alert status and channel enables
    logic [NCHAN-1:0] st_lo_r;
    logic [NCHAN-1:0] st_hi_r;
    logic [NCHAN-1:0] ch_en_r;
    logic             alert_wr;
    logic [DATA_W-1:0] alert_word;

    assign alert_wr = wr_hit && (w_addr == WA_ALERT);

    // hardware set beats a software clear in the same cycle
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            st_lo_r <= '0;
            st_hi_r <= '0;
        end
        else
        begin
            st_lo_r <= (alert_wr ? (st_lo_r & w_data[ST_LO_LSB +: NCHAN])
                                 : st_lo_r) | LIMIT_LO;
            st_hi_r <= (alert_wr ? (st_hi_r & w_data[ST_HI_LSB +: NCHAN])
                                 : st_hi_r) | LIMIT_HI;
        end
    end

    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
            ch_en_r <= '0;
        else if (alert_wr)
            ch_en_r <= w_data[ST_EN_LSB +: NCHAN];
    end

    // own word, so the register array keeps a single kind of driver
    always_comb
    begin
        alert_word = '0;
        alert_word[ST_LO_LSB +: NCHAN] = st_lo_r;
        alert_word[ST_HI_LSB +: NCHAN] = st_hi_r;
        alert_word[ST_EN_LSB +: NCHAN] = ch_en_r;
    end

    // =====================================================
    // gpio configuration
    logic [GPIO_W-1:0] cfg_a_r;
    logic [GPIO_W-1:0] cfg_b_r;
    logic [NPIN-1:0]   pin_en;
    logic [NPIN-1:0]   pin_dir;
    logic [NPIN-1:0]   pin_sense;
    logic [NPIN-1:0]   irq_permit_bit;

    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            cfg_a_r <= RST8;
            cfg_b_r <= RST8;
        end
        else if (frame_ev)
        begin
            if (ext_hit(EA_CFG_A, w_addr, e_addr))
                cfg_a_r <= e_data;
            if (ext_hit(EA_CFG_B, w_addr, e_addr))
                cfg_b_r <= e_data;
        end
    end

    generate
        for (gi = 0; gi < NPIN; gi++)
        begin : g_cfg
            localparam int B = (gi % 2) * NIB;
            logic [NIB-1:0] nib;
            assign nib = (gi < 2) ? cfg_a_r[B +: NIB]
                                  : cfg_b_r[B +: NIB];
            // dedicated pin has no analog use, so its enable is forced
            assign pin_en[gi]         = (gi == NPIN-1) ? 1'b1
                                                       : nib[F_EN];
            assign pin_dir[gi]        = nib[F_DIR];
            assign pin_sense[gi]      = nib[F_SENSE];
            assign irq_permit_bit[gi] = nib[F_PERMIT];
        end
    endgenerate

    assign AUX_ANALOG = ~pin_en[NPIN-2:0];

    // =====================================================
    // gpio input synchroniser, change taken when stages 2 and 3 agree
    logic [NPIN-1:0] gi_s1_r;
    logic [NPIN-1:0] gi_s2_r;
    logic [NPIN-1:0] gi_s3_r;
    logic [NPIN-1:0] gi_lvl_r;

    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            gi_s1_r  <= '0;
            gi_s2_r  <= '0;
            gi_s3_r  <= '0;
            gi_lvl_r <= '0;
        end
        else
        begin
            gi_s1_r  <= GPIO_IN;
            gi_s2_r  <= gi_s1_r;
            gi_s3_r  <= gi_s2_r;
            gi_lvl_r <= (gi_s2_r & gi_s3_r)
                      | (gi_lvl_r & (gi_s2_r | gi_s3_r));
        end
    end

    // =====================================================
    // gpio data register
    logic [NPIN-1:0] data_r;
    logic [NPIN-1:0] is_in;

    assign is_in = pin_en & pin_dir;

    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
            data_r <= '0;
        else
        begin
            for (int i = 0; i < NPIN; i++)
            begin
                if (is_in[i])
                    data_r[i] <= pin_sense[i] ? gi_lvl_r[i]
                                              : ~gi_lvl_r[i];
                else if (frame_ev && ext_hit(EA_DATA, w_addr, e_addr))
                    data_r[i] <= e_data[i];
            end
        end
    end

    // output pins take data through a flop, inverted where the pin's sense bit is clear
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            GPIO_OUT <= '0;
            GPIO_OE  <= '0;
        end
        else
        begin
            GPIO_OUT <= ~(data_r ^ pin_sense);
            GPIO_OE  <= pin_en & ~pin_dir;
        end
    end

    // =====================================================
    // alarm
    logic gpio_alarm;
    logic limit_alarm;

    assign gpio_alarm  = |(is_in & irq_permit_bit & data_r);
    assign limit_alarm = |((st_lo_r | st_hi_r) & ch_en_r);

    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
            ALERT_N <= 1'b1;
        else
            ALERT_N <= ~(gpio_alarm | limit_alarm);
    end

    // =====================================================
    // read pointer and read word
    function automatic logic [WORD_W-1:0] read_word(
        input logic [PTR_W-1:0] p);
        read_word = '0;
        if (p == PTR_W'(WA_ALERT))
            read_word = {{(WORD_W-DATA_W){1'b0}}, alert_word};
        else if (p >= PTR_W'(WA_CTRL1) && p <= PTR_W'(WA_LAST))
            read_word = {{(WORD_W-DATA_W){1'b0}},
                         regs_r[ADDR_W'(p)]};
        else if (p == RA_CFG_A)
            read_word = {{(WORD_W-GPIO_W){1'b0}}, cfg_a_r};
        else if (p == RA_CFG_B)
            read_word = {{(WORD_W-GPIO_W){1'b0}}, cfg_b_r};
        else if (p == RA_DATA)
            read_word = {{(WORD_W-NPIN){1'b0}}, data_r};
    endfunction

    // every completed frame was also a read; a control write overrides
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
            ptr_r <= '0;
        else if (wr_hit && w_addr == WA_CTRL1)
            ptr_r <= w_data[PTR_LSB +: PTR_W];
        else if (frame_ev)
            ptr_r <= (ptr_r == RA_MAX) ? '0
                                       : ptr_r + 5'h01;
    end

    // limitation: word changes only between frames, host must pause
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
            lk.tx_word <= '0;
        else
            lk.tx_word <= read_word(ptr_r);
    end

    // =====================================================
    // write notification for the rest of the device
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            WR_STROBE <= 1'b0;
            WR_ADDR   <= '0;
            WR_DATA   <= '0;
        end
        else
        begin
            WR_STROBE <= wr_hit;
            if (wr_hit)
            begin
                WR_ADDR <= w_addr;
                WR_DATA <= w_data;
            end
        end
    end
endmodule
`default_nettype wire

// File: verif/tsc_serial_gpio_assertions.sv
// checker: port-level timing of the serial gpio block
// assumes: bound into tsc_serial_gpio, everything sampled on CLK
`timescale 1ns/1ps
`default_nettype none
module tsc_serial_gpio_assertions
    import tsc_pkg::*;
(
    // clock and reset
    input  wire logic              CLK,
    input  wire logic              RESETN,
    // watched ports
    input  wire logic              CS_N,
    input  wire logic              SER_OUT,
    input  wire logic              SER_OUT_OE,
    input  wire logic [NPIN-1:0]   GPIO_OE,
    input  wire logic [NPIN-2:0]   AUX_ANALOG,
    input  wire logic [DATA_W-1:0] CTRL_WORD,
    input  wire logic              WR_STROBE,
    input  wire logic [ADDR_W-1:0] WR_ADDR,
    input  wire logic [DATA_W-1:0] WR_DATA
);
    // ==========================================
    // properties
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RESETN);

    sequence cs_idle_s;
        CS_N [*8];
    endsequence
    sequence wr_seen_s;
        WR_STROBE || $past(WR_STROBE);
    endsequence

    a_oe_follows_cs: assert property (SER_OUT_OE == !CS_N)
        else $error("output enable differs from select");
    a_out_idle_low: assert property (CS_N |-> !SER_OUT)
        else $error("serial output active while deselected");
    a_msb_leads_zero: assert property ($fell(CS_N) |-> (!SER_OUT) [*8])
        else $error("leading read bit not zero");
    a_strobe_single: assert property (WR_STROBE |=> !WR_STROBE)
        else $error("write strobe longer than one cycle");
    a_strobe_addr_ok: assert property (WR_STROBE |-> ##[0:1]
        (WR_ADDR != WA_DUMMY && WR_ADDR != WA_EXT))
        else $error("strobe for dummy or extended address");
    a_wr_regs_hold: assert property
        (($changed(WR_ADDR) || $changed(WR_DATA)) |-> wr_seen_s)
        else $error("write registers moved without strobe");
    a_ctrl_from_write: assert property ($changed(CTRL_WORD) |->
        ##[0:1] (WR_ADDR == WA_CTRL1 && WR_DATA == CTRL_WORD))
        else $error("control word changed without its write");
    a_idle_no_write: assert property (cs_idle_s |=> !WR_STROBE)
        else $error("write while select idle");
    a_analog_no_drive: assert property
        ((AUX_ANALOG & $past(AUX_ANALOG) & GPIO_OE[NPIN-2:0]) == 3'h0)
        else $error("analog pin driven");
endmodule

bind tsc_serial_gpio tsc_serial_gpio_assertions u_chk (
    .CLK(CLK), .RESETN(RESETN), .CS_N(CS_N), .SER_OUT(SER_OUT),
    .SER_OUT_OE(SER_OUT_OE), .GPIO_OE(GPIO_OE), .AUX_ANALOG(AUX_ANALOG),
    .CTRL_WORD(CTRL_WORD), .WR_STROBE(WR_STROBE), .WR_ADDR(WR_ADDR),
    .WR_DATA(WR_DATA)
);
`default_nettype wire

// File: verif/tsc_host_model.sv
// model: host master on the serial link, 64 ns bit clock
// assumes: bit clock stands low outside frames
`timescale 1ns/1ps
`default_nettype none
module tsc_host_model (
    // link pins
    output logic      sclk,
    output logic      cs_n,
    output logic      mosi,
    input  wire logic miso
);
    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end

    // ==========================================
    // one frame, nb bits msb first; nb < 16 cuts it short
    task automatic xfer(input logic [15:0] w, input int nb,
                        output logic [15:0] r);
        int i;
        r = 16'h0000;
        #13.7;
        cs_n = 1'b0;
        for (i = 15; i > 15 - nb; i--)
        begin
            mosi = w[i];
            #32;
            r[i] = miso;
            sclk = 1'b1;
            #32;
            sclk = 1'b0;
        end
        #32;
        cs_n = 1'b1;
        mosi = ~mosi;
        // long gap lets the read word settle
        #200;
    endtask
endmodule
`default_nettype wire

// File: verif/tsc_serial_gpio_tb_top.sv
// testbench: register map, readback, gpio and alarm scenarios
// assumes: package, interface, design, checker and host model compiled
`timescale 1ns/1ps
`default_nettype none
module tsc_serial_gpio_tb_top
    import tsc_pkg::*;
;
    logic              clk;
    logic              rst_n;
    logic              sclk;
    logic              cs_n;
    logic              mosi;
    logic              miso;
    logic [NPIN-1:0]   pin_drv;
    logic [NPIN-1:0]   pin_lvl;
    logic [NPIN-1:0]   g_out;
    logic [NPIN-1:0]   g_oe;
    logic [NPIN-2:0]   aux;
    logic [NCHAN-1:0]  lim_hi;
    logic [NCHAN-1:0]  lim_lo;
    logic              alert_n;
    logic [DATA_W-1:0] ctrl;
    logic              wr_stb;
    logic [ADDR_W-1:0] wr_addr;
    logic [DATA_W-1:0] wr_data;
    logic [15:0]       rx;
    int                err_total;
    int                total_checks;

    // pin wire: driven level wins over the outside level
    assign pin_lvl = (g_oe & g_out) | (~g_oe & pin_drv);

    initial
        clk = 1'b0;
    always #2.5 clk = ~clk;

    tsc_serial_gpio dut (
        .CLK(clk), .RESETN(rst_n), .SERIAL_BIT_CLOCK(sclk), .CS_N(cs_n),
        .SER_IN(mosi), .SER_OUT(miso), .SER_OUT_OE(), .GPIO_IN(pin_lvl),
        .GPIO_OUT(g_out), .GPIO_OE(g_oe), .AUX_ANALOG(aux),
        .LIMIT_HI(lim_hi), .LIMIT_LO(lim_lo), .ALERT_N(alert_n),
        .CTRL_WORD(ctrl), .WR_STROBE(wr_stb), .WR_ADDR(wr_addr),
        .WR_DATA(wr_data)
    );
    tsc_host_model host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));

    // ==========================================
    // shared tasks
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("checks=%0d mismatches=%0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic wr(input logic [15:0] w);
        host.xfer(w, 16, rx);
    endtask
    task automatic setp(input logic [4:0] p);
        wr({4'h1, 5'h00, p, 2'h0});
    endtask
    task automatic rd0(input logic [15:0] exp);
        host.xfer(16'h0000, 16, rx);
        chk(rx, exp);
    endtask
    task automatic wait_alert(input logic e);
        int n;
        for (n = 0; n < 30 && alert_n !== e; n++)
            @(posedge clk) #1;
        chk({15'h0, alert_n}, {15'h0, e});
        if (alert_n !== e)
            summarize();
    endtask
    task automatic pulse(input logic [3:0] h, input logic [3:0] l);
        @(posedge clk) #1;
        lim_hi = h;
        lim_lo = l;
        @(posedge clk) #1;
        lim_hi = 4'h0;
        lim_lo = 4'h0;
    endtask

    // ==========================================
    // scenarios
    task automatic t_reset();
        chk({4'h0, alert_n, g_oe, g_out, aux}, 16'h0807);
        chk({4'h0, ctrl}, 16'h0000);
    endtask
    task automatic t_write_map();
        int a;
        for (a = 2; a < 15; a++)
        begin
            wr({a[3:0], a[3:0], 8'h5a});
            chk({12'h0, wr_addr}, 16'(a));
            chk({4'h0, wr_data}, {4'h0, a[3:0], 8'h5a});
        end
        wr(16'h0abc);
        chk({4'h0, wr_data}, 16'h0e5a);
        setp(5'h04);
        for (a = 4; a < 15; a++)
            rd0({4'h0, a[3:0], 8'h5a});
    endtask
    task automatic t_wrap();
        setp(5'h1f);
        chk({4'h0, ctrl}, 16'h007c);
        rd0(16'h0000);
        rd0(16'h0000);
        rd0(16'h007c);
    endtask
    task automatic t_short();
        host.xfer(16'h2fff, 8, rx);
        chk({12'h0, wr_addr}, 16'h0001);
        setp(5'h02);
        rd0(16'h025a);
    endtask
    task automatic t_gpio_out();
        wr(16'hf015);
        wr(16'hf203);
        chk({12'h0, g_oe}, 16'h000b);
        chk({14'h0, g_out[1:0]}, 16'h0001);
        chk({13'h0, aux}, 16'h0004);
        setp(RA_CFG_A);
        rd0(16'h0015);
        rd0(16'h0000);
        rd0(16'h0003);
    endtask
    task automatic t_gpio_in();
        wr(16'hf16f);
        @(posedge clk) #1 pin_drv = 4'b1100;
        wait_alert(1'b0);
        chk({12'h0, g_oe}, 16'h0003);
        setp(RA_DATA);
        rd0(16'h000f);
        @(posedge clk) #1 pin_drv = 4'b0000;
        wait_alert(1'b1);
        wr(16'hf204);
        setp(RA_DATA);
        rd0(16'h0000);
        @(posedge clk) #1 pin_drv = 4'b0100;
        wait_alert(1'b0);
        wr(16'hf167);
        wait_alert(1'b1);
    endtask
    task automatic t_limit();
        wr(16'h3100);
        pulse(4'h1, 4'h0);
        wait_alert(1'b0);
        setp(5'h03);
        rd0(16'h0110);
        wr(16'h3100);
        wait_alert(1'b1);
        pulse(4'h0, 4'h2);
        repeat (30) @(posedge clk);
        #1;
        chk({15'h0, alert_n}, 16'h0001);
        setp(5'h03);
        rd0(16'h0102);
        pulse(4'h0, 4'h1);
        wait_alert(1'b0);
        wr(16'h3000);
        wait_alert(1'b1);
    endtask

    initial
    begin
        err_total = 0;
        total_checks = 0;
        rst_n = 1'b0;
        pin_drv = 4'h0;
        lim_hi = 4'h0;
        lim_lo = 4'h0;
        repeat (10) @(posedge clk);
        #1;
        t_reset();
        repeat (10) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (4) @(posedge clk);
        t_write_map();
        t_wrap();
        t_short();
        t_gpio_out();
        t_gpio_in();
        t_limit();
        summarize();
    end
endmodule
`default_nettype wire
